// ==== logic/_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== logic/hobl_coord_wrap.sv ====
`default_nettype none
module hobl_coord_wrap (
    hobl_wrap_if.unit w
);
    logic signed [33:0] width;
    logic signed [33:0] lo_x;
    logic signed [33:0] hi_x;
    logic signed [33:0] r;

    // Coordinate width is end minus start plus one.
    assign lo_x  = 34'(w.lo);
    assign hi_x  = 34'(w.hi);
    assign width = hi_x - lo_x + 34'sd1;

    // Fold the value back into start..end on rotary axes; linear passes it unchanged.
    always_comb begin
        r = w.value;
        if (w.rotary) begin
            if (w.value < lo_x) begin
                r = w.value + width;
            end else if (w.value > hi_x) begin
                r = w.value - width;
            end
        end
    end

    assign w.result = r[31:0];
endmodule : hobl_coord_wrap
`default_nettype wire

// ==== logic/hobl_pkg.sv ====
`default_nettype none
package hobl_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_COORD_TYPE  = 8'h04;
    localparam logic [7:0]  ADDR_END_POINT   = 8'h08;
    localparam logic [7:0]  ADDR_START_POINT = 8'h0C;
    localparam logic [7:0]  ADDR_ORIGIN      = 8'h10;
    localparam logic [7:0]  ADDR_BACKLASH    = 8'h14;
    localparam logic [7:0]  ADDR_TARGET      = 8'h18;
    localparam logic [7:0]  ADDR_CMD_POS     = 8'h1C;
    localparam logic [7:0]  ADDR_MOTOR_POS   = 8'h20;
    localparam logic [7:0]  ADDR_ORIGIN_ACT  = 8'h24;
    localparam logic [7:0]  ADDR_DESIRED     = 8'h28;

    // Command bits written to the control register.
    localparam int          CMD_RESTART_BIT  = 0;
    localparam int          CMD_ZERO_SET_BIT = 1;
    localparam int          CMD_HOME_SET_BIT = 2;
    localparam int          CMD_MOVE_BIT     = 3;
    localparam int          CMD_HOME_BIT     = 4;
    localparam int          CMD_HOME_DIR_BIT = 5;

    // Status bits read from the control register.
    localparam int          ST_BUSY_BIT      = 0;
    localparam int          ST_DIR_BIT       = 1;
    localparam int          ST_ABS_BIT       = 2;
    localparam int          ST_REF_BIT       = 3;
    localparam int          ST_TORQUE_BIT    = 4;

    // Coordinate type codes.
    localparam logic [1:0]  COORD_LINEAR     = 2'h0;
    localparam logic [1:0]  COORD_SHORTEST   = 2'h1;
    localparam logic [1:0]  COORD_FORWARD    = 2'h2;
    localparam logic [1:0]  COORD_REVERSE    = 2'h3;

    // Factory values and legal ranges.
    localparam logic signed [31:0] END_POINT_RST   = 32'h0098_967F;
    localparam logic signed [31:0] START_POINT_RST = 32'hFF67_6981;
    localparam logic signed [31:0] ORIGIN_RST      = 32'h0000_0000;
    localparam logic signed [31:0] BACKLASH_RST    = 32'h0000_0000;
    localparam logic signed [31:0] BACKLASH_MAX    = 32'h0000_03E8;
    localparam logic signed [31:0] BACKLASH_MIN    = 32'hFFFF_FC18;
    localparam logic signed [31:0] COORD_MAX       = 32'h05F5_E0FF;
    localparam logic signed [31:0] COORD_MIN       = 32'hFA0A_1F01;

    // Bus encodings.
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;

    // Step timing of the position generator.
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          STEP_TIME_NS     = 1000;
    localparam int          STEP_CYCLES      = STEP_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic {MV_IDLE, MV_RUN} hobl_move_e;

endpackage : hobl_pkg
`default_nettype wire

// ==== logic/hobl_top.sv ====
`default_nettype none
module hobl_top
    import hobl_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        ENC_ABSOLUTE,
    input  wire logic [31:0] ABS_ENC_POS,
    output logic      [31:0] MOTOR_POS,
    output logic             MOVE_BUSY,
    output logic             MOVE_DIR
);

    logic                     abs_meta;
    logic                     abs_sync;
    logic [2:0]               por_sr;
    logic                     por_load;
    logic                     addr_ok;
    logic                     wr_q;
    logic                     hit_q;
    logic [7:0]               addr_q;
    logic [31:0]              rd_mux;
    logic                     wr_ctrl;
    logic                     cmd_restart;
    logic                     cmd_set_home;
    logic                     cmd_move;
    logic                     cmd_home;
    logic                     load_evt;
    logic [1:0]               pend_coord;
    logic signed [31:0]       pend_end;
    logic signed [31:0]       pend_start;
    logic signed [31:0]       pend_origin;
    logic [1:0]               act_coord;
    logic signed [31:0]       act_end;
    logic signed [31:0]       act_start;
    logic signed [31:0]       act_origin;
    logic                     abs_active;
    logic signed [31:0]       backlash;
    logic signed [31:0]       target;
    logic signed [31:0]       desired;
    logic signed [31:0]       cmd_pos;
    logic signed [31:0]       comp;
    logic signed [31:0]       bl_amt;
    logic                     move_dir;
    logic                     ref_dir;
    logic                     ref_valid;
    hobl_move_e               state;
    logic [7:0]               step_cnt;
    logic                     step_en;
    logic signed [33:0]       diff;
    logic signed [33:0]       width;
    logic signed [33:0]       fwd_dist;
    logic                     want_dir;
    logic                     apply_comp;
    logic signed [31:0]       step_next;

    hobl_wrap_if wif ();

    hobl_coord_wrap u_wrap (
        .w (wif)
    );

    // Saturate a written value into its legal range.
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp

    // The encoder-type strap comes from a pin, so it passes two flip-flops.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            abs_meta <= 1'b0;
            abs_sync <= 1'b0;
        end else begin
            abs_meta <= ENC_ABSOLUTE;
            abs_sync <= abs_meta;
        end
    end

    // Power-on load fires once, after the strap synchroniser has settled.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            por_sr <= 3'h0;
        end else begin
            por_sr <= {por_sr[1:0], 1'b1};
        end
    end
    assign por_load = por_sr[1] & ~por_sr[2];

    // Bus address phase; only whole-word writes are accepted.
    assign addr_ok = HSEL & HTRANS[1] & HREADY;
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            wr_q   <= 1'b0;
            hit_q  <= 1'b0;
            addr_q <= 8'h00;
        end else if (HREADY) begin
            wr_q   <= addr_ok & HWRITE & (HSIZE == HSIZE_WORD);
            hit_q  <= (HADDR[31:8] == 24'h00_0000);
            addr_q <= HADDR[7:0];
        end
    end

    // The slave never stalls and always answers OKAY.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Read multiplexer; the command-position monitor shows the commanded value without compensation, the motor monitor includes it.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (HADDR[31:8] == 24'h00_0000) begin
            unique case (HADDR[7:0])
                ADDR_CTRL:        rd_mux = {27'h000_0000, 1'b1, ref_valid, abs_active, move_dir,
                                            state == MV_RUN};
                ADDR_COORD_TYPE:  rd_mux = {30'h0000_0000, pend_coord};
                ADDR_END_POINT:   rd_mux = pend_end;
                ADDR_START_POINT: rd_mux = pend_start;
                ADDR_ORIGIN:      rd_mux = pend_origin;
                ADDR_BACKLASH:    rd_mux = backlash;
                ADDR_TARGET:      rd_mux = target;
                ADDR_CMD_POS:     rd_mux = cmd_pos;
                ADDR_MOTOR_POS:   rd_mux = MOTOR_POS;
                ADDR_ORIGIN_ACT:  rd_mux = act_origin;
                ADDR_DESIRED:     rd_mux = desired;
                default:          rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Read data are registered at the address phase and stand in the data phase.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            HRDATA <= rd_mux;
        end
    end

    // Command pulses decoded from a data-phase write to the control register.
    assign wr_ctrl      = wr_q & hit_q & (addr_q == ADDR_CTRL);
    assign cmd_restart  = wr_ctrl & HWDATA[CMD_RESTART_BIT];
    assign cmd_set_home = wr_ctrl & (HWDATA[CMD_ZERO_SET_BIT] | HWDATA[CMD_HOME_SET_BIT]) & abs_active;
    assign cmd_move     = wr_ctrl & HWDATA[CMD_MOVE_BIT];
    assign cmd_home     = wr_ctrl & HWDATA[CMD_HOME_BIT] & ~abs_active;
    assign load_evt     = por_load | cmd_restart;

    // One wrap unit serves the restart load and the home set.
    assign wif.value  = load_evt ? 34'(signed'(ABS_ENC_POS)) + 34'(pend_origin)
                                 : 34'(act_origin) + 34'(desired) - 34'(cmd_pos);
    assign wif.lo     = load_evt ? pend_start : act_start;
    assign wif.hi     = load_evt ? pend_end : act_end;
    assign wif.rotary = load_evt ? (pend_coord != COORD_LINEAR) : (act_coord != COORD_LINEAR);

    // Software-written parameters; end, start, origin and backlash are clamped to their ranges on write.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pend_coord  <= COORD_LINEAR;
            pend_end    <= END_POINT_RST;
            pend_start  <= START_POINT_RST;
            pend_origin <= ORIGIN_RST;
            backlash    <= BACKLASH_RST;
            target      <= 32'h0000_0000;
            desired     <= 32'h0000_0000;
        end else begin
            if (cmd_set_home) begin
                pend_origin <= wif.result;
            end else if (wr_q && hit_q && addr_q == ADDR_ORIGIN) begin
                pend_origin <= clamp(HWDATA, COORD_MIN, COORD_MAX);
            end
            if (wr_q && hit_q) begin
                unique case (addr_q)
                    ADDR_COORD_TYPE:  pend_coord <= HWDATA[1:0];
                    ADDR_END_POINT:   pend_end   <= clamp(HWDATA, COORD_MIN, COORD_MAX);
                    ADDR_START_POINT: pend_start <= clamp(HWDATA, COORD_MIN, COORD_MAX);
                    ADDR_BACKLASH:    backlash   <= clamp(HWDATA, BACKLASH_MIN, BACKLASH_MAX);
                    ADDR_TARGET:      target     <= HWDATA;
                    ADDR_DESIRED:     desired    <= HWDATA;
                    default:          ;
                endcase
            end
        end
    end

    // Active coordinate settings change only at a restart, except the active origin, which a home set also loads.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            act_coord  <= COORD_LINEAR;
            act_end    <= END_POINT_RST;
            act_start  <= START_POINT_RST;
            act_origin <= ORIGIN_RST;
            abs_active <= 1'b0;
        end else if (load_evt) begin
            act_coord  <= pend_coord;
            act_end    <= pend_end;
            act_start  <= pend_start;
            act_origin <= pend_origin;
            abs_active <= abs_sync;
        end else if (cmd_set_home) begin
            act_origin <= wif.result;
        end
    end

    // Slow step enable for the position generator.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            step_cnt <= 8'h00;
            step_en  <= 1'b0;
        end else if (step_cnt == 8'(STEP_CYCLES - 1)) begin
            step_cnt <= 8'h00;
            step_en  <= 1'b1;
        end else begin
            step_cnt <= step_cnt + 8'h01;
            step_en  <= 1'b0;
        end
    end

    // Move direction from the coordinate type and the target.
    assign diff     = 34'(target) - 34'(cmd_pos);
    assign width    = 34'(act_end) - 34'(act_start) + 34'sd1;
    assign fwd_dist = (diff < 0) ? diff + width : diff;
    always_comb begin
        unique case (act_coord)
            COORD_LINEAR:   want_dir = (diff > 0);
            COORD_SHORTEST: want_dir = ((fwd_dist <<< 1) <= width);
            COORD_FORWARD:  want_dir = 1'b1;
            COORD_REVERSE:  want_dir = 1'b0;
        endcase
    end

    // Compensate only against the reference direction and with the matching sign.
    assign apply_comp = ref_valid && (want_dir != ref_dir)
                        && ((want_dir && backlash > 0) || (!want_dir && backlash < 0));

    // Next step, wrapping at the rotary end points.
    always_comb begin
        step_next = move_dir ? cmd_pos + 32'sd1 : cmd_pos - 32'sd1;
        if (act_coord != COORD_LINEAR) begin
            if (move_dir && cmd_pos == act_end) begin
                step_next = act_start;
            end else if (!move_dir && cmd_pos == act_start) begin
                step_next = act_end;
            end
        end
    end

    // Commanded position, reference direction and compensation.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cmd_pos   <= 32'h0000_0000;
            comp      <= 32'h0000_0000;
            bl_amt    <= BACKLASH_RST;
            move_dir  <= 1'b1;
            ref_dir   <= 1'b1;
            ref_valid <= 1'b0;
            state     <= MV_IDLE;
        end else if (load_evt) begin
            cmd_pos   <= abs_sync ? wif.result : pend_origin;
            comp      <= 32'h0000_0000;
            ref_valid <= 1'b0;
            state     <= MV_IDLE;
        end else begin
            unique case (state)
                MV_IDLE: begin
                    if (cmd_home) begin
                        cmd_pos   <= act_origin;
                        ref_dir   <= HWDATA[CMD_HOME_DIR_BIT];
                        ref_valid <= 1'b1;
                        comp      <= 32'h0000_0000;
                    end else if (cmd_set_home) begin
                        cmd_pos <= desired;
                    end else if (cmd_move && diff != 0) begin
                        bl_amt   <= backlash;
                        comp     <= apply_comp ? backlash : 32'h0000_0000;
                        move_dir <= want_dir;
                        state    <= MV_RUN;
                        if (!ref_valid && abs_active) begin
                            ref_dir   <= want_dir;
                            ref_valid <= 1'b1;
                        end
                    end
                end
                MV_RUN: begin
                    if (cmd_pos == target) begin
                        state <= MV_IDLE;
                    end else if (step_en) begin
                        cmd_pos <= step_next;
                    end
                end
            endcase
        end
    end

    // Motor output carries the compensation; the commanded position stays clean.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            MOTOR_POS <= 32'h0000_0000;
            MOVE_BUSY <= 1'b0;
            MOVE_DIR  <= 1'b1;
        end else begin
            MOTOR_POS <= cmd_pos + comp;
            MOVE_BUSY <= (state == MV_RUN);
            MOVE_DIR  <= move_dir;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    restart_load_a: assert property (load_evt |=> act_origin == $past(pend_origin))
        else $error("Active origin not loaded at restart.");
    incr_home_a: assert property (cmd_home && state == MV_IDLE && !load_evt |=> cmd_pos == $past(act_origin))
        else $error("Homing did not load the origin.");
    zero_set_a: assert property (cmd_set_home && state == MV_IDLE && !load_evt
                                 |=> cmd_pos == $past(desired) && act_origin == $past(wif.result))
        else $error("Home set did not give the desired position.");
    backlash_range_a: assert property (backlash >= BACKLASH_MIN && backlash <= BACKLASH_MAX)
        else $error("Backlash amount out of range.");
    comp_sign_a: assert property (comp != 0 && state == MV_RUN |-> comp[31] == !move_dir)
        else $error("Compensation sign disagrees with direction.");
    amount_hold_a: assert property (state == MV_RUN && $past(state) == MV_RUN |-> $stable(bl_amt))
        else $error("Backlash amount changed during a move.");
    ref_oppose_a: assert property (comp != 0 |-> ref_valid && move_dir != ref_dir)
        else $error("Compensation applied in the reference direction.");
    motor_comp_a: assert property (##1 MOTOR_POS == $past(cmd_pos) + $past(comp))
        else $error("Motor position misses the compensation.");
    monitor_clean_a: assert property (addr_ok && !HWRITE && HADDR == 32'(ADDR_CMD_POS)
                                      |=> HRDATA == $past(cmd_pos))
        else $error("Position monitor does not show the commanded value.");
    point_range_a: assert property (pend_end <= COORD_MAX && pend_start >= COORD_MIN)
        else $error("Coordinate point out of range.");

endmodule : hobl_top
`default_nettype wire

// ==== logic/hobl_wrap_if.sv ====
`default_nettype none
// Carries one offset through the rotary wrap unit.
interface hobl_wrap_if;
    logic signed [33:0] value;
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic               rotary;
    logic signed [31:0] result;

    modport client (output value, output lo, output hi, output rotary, input result);
    modport unit   (input value, input lo, input hi, input rotary, output result);
endinterface : hobl_wrap_if
`default_nettype wire

// ==== verification/hobl_host.sv ====
`default_nettype none
// Host controller model: single word transfers and the home offset arithmetic.
module hobl_host
    import hobl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // The bus stands idle until the first transfer.
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = HSIZE_WORD;
        hwdata = 32'h0;
    end

    // One transfer, entered just after a rising edge; it ends at the edge that closes the data phase.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    // New offset that makes the present position read as the desired one.
    function automatic logic signed [31:0] new_origin(input logic signed [31:0] org, des, cur, lo, hi,
                                                     input logic rot);
        logic signed [33:0] v;
        v = 34'(org) + 34'(des) - 34'(cur);
        if (rot && v < 34'(lo)) begin
            v = v + 34'(hi) - 34'(lo) + 34'sh1;
        end
        if (rot && v > 34'(hi)) begin
            v = v - 34'(hi) + 34'(lo) - 34'sh1;
        end
        return v[31:0];
    endfunction : new_origin

    // Checks a pitch against the highest scale pitch that keeps full motor speed for a reported scale resolution.
    function automatic logic pitch_ok(input logic [7:0] scale_bits, input logic [31:0] pitch);
        logic [31:0] lim;
        lim = 32'h0000_0000;
        case (scale_bits)
            8'h08:   lim = 32'h0000_FE4F;
            8'h09:   lim = 32'h0000_7F27;
            8'h0A:   lim = 32'h0000_3F93;
            8'h0D:   lim = 32'h0000_07F2;
            default: lim = 32'h0000_0000;
        endcase
        return (pitch <= lim);
    endfunction : pitch_ok
endmodule : hobl_host
`default_nettype wire

// ==== verification/home_offset_backlash_tb.sv ====
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
// Bus rows first, then origin, homing and compensation cases.
module home_offset_backlash_tb
    import hobl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} hobl_row_s;
    logic        clk;
    logic        resetn;
    logic        enc_abs;
    logic        hsel, hwrite, hreadyout, hresp, move_busy, move_dir;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, abs_pos, motor_pos, o;
    int          n_fail = 0;
    int          tests_run = 0;
    hobl_row_s   rows [0:11] = '{
        '{1'b0, ADDR_COORD_TYPE, 32'h0, 32'h0}, '{1'b0, ADDR_END_POINT, 32'h0, END_POINT_RST},
        '{1'b0, ADDR_START_POINT, 32'h0, START_POINT_RST}, '{1'b0, ADDR_ORIGIN, 32'h0, ORIGIN_RST},
        '{1'b0, ADDR_BACKLASH, 32'h0, BACKLASH_RST}, '{1'b1, 8'h30, 32'h5, 32'h0},
        '{1'b1, ADDR_BACKLASH, 32'h0000_07D0, BACKLASH_MAX}, '{1'b1, ADDR_BACKLASH, 32'hFFFF_EC78, BACKLASH_MIN},
        '{1'b1, ADDR_END_POINT, 32'h0BEB_C200, COORD_MAX}, '{1'b1, ADDR_START_POINT, 32'hF414_3E00, COORD_MIN},
        '{1'b1, ADDR_COORD_TYPE, 32'h3, 32'h3}, '{1'b1, ADDR_COORD_TYPE, 32'h0, 32'h0}};

    hobl_top dut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .ENC_ABSOLUTE(enc_abs), .ABS_ENC_POS(abs_pos),
        .MOTOR_POS(motor_pos), .MOVE_BUSY(move_busy), .MOVE_DIR(move_dir));
    hobl_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // Free running clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // Register helpers built on the host transfer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host.xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] x;
        host.xfer(1'b0, a, 32'h0, x);
        `CHK(nm, e, x)
    endtask : rdc
    task automatic restart;
        wr(ADDR_CTRL, 32'h0000_0001);
        repeat (6) @(posedge clk);
    endtask : restart

    // Starts a move and checks the busy flag two edges later; it rises at the first.
    task automatic go(input logic [31:0] t);
        wr(ADDR_TARGET, t);
        wr(ADDR_CTRL, 32'h0000_0008);
        repeat (2) @(posedge clk);
        #1;
        `CHK("busy", 1'b1, move_busy)
        @(posedge clk);
    endtask : go
    task automatic idle;
        int n;
        n = 0;
        #1;
        while (move_busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        n_fail += (n >= 3000);
        @(posedge clk);
    endtask : idle

    // Watchdog against a hang.
    initial begin
        #5_000_000;
        n_fail++;
        conclude();
    end

    // Main sequence.
    initial begin
        resetn  = 1'b0;
        enc_abs = 1'b0;
        abs_pos = 32'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(ADDR_CTRL, 32'h0000_0012, "status");
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end
            rdc(rows[i].a, rows[i].e, "row");
        end
        // Incremental encoder: origin load, homing and compensation.
        wr(ADDR_ORIGIN, 32'h0000_0032);
        rdc(ADDR_CMD_POS, 32'h0, "cmd before restart");
        restart();
        rdc(ADDR_CMD_POS, 32'h0000_0032, "cmd at load");
        wr(ADDR_CTRL, 32'h0000_0030);
        rdc(ADDR_CTRL, 32'h0000_001A, "homed status");
        wr(ADDR_BACKLASH, 32'hFFFF_FFF9);
        go(32'h0000_002D);
        wr(ADDR_BACKLASH, 32'hFFFF_FFFD);
        idle();
        rdc(ADDR_CMD_POS, 32'h0000_002D, "cmd");
        `CHK("motor", 32'h0000_0026, motor_pos)
        `CHK("dir", 1'b0, move_dir)
        go(32'h0000_0030);
        idle();
        `CHK("motor", 32'h0000_0030, motor_pos)
        wr(ADDR_CTRL, 32'h0000_0010);
        rdc(ADDR_CMD_POS, 32'h0000_0032, "cmd at home");
        wr(ADDR_BACKLASH, 32'h0000_0006);
        go(32'h0000_0035);
        idle();
        `CHK("motor", 32'h0000_003B, motor_pos)
        rdc(ADDR_TARGET, 32'h0000_0035, "target");
        // Absolute encoder: offset recomputed by the host, zero set and home set.
        wr(ADDR_ORIGIN, 32'h0);
        enc_abs <= 1'b1;
        abs_pos <= 32'h0000_03E8;
        // The strap needs two edges through its synchroniser before the restart samples it.
        repeat (2) @(posedge clk);
        restart();
        host.xfer(1'b0, ADDR_CMD_POS, 32'h0, o);
        `CHK("abs cmd", 32'h0000_03E8, o)
        wr(ADDR_ORIGIN, host.new_origin(32'h0, 32'h0, o, 32'h0, 32'h0, 1'b0));
        restart();
        rdc(ADDR_CMD_POS, 32'h0, "cmd after offset");
        wr(ADDR_DESIRED, 32'h0000_0005);
        wr(ADDR_CTRL, 32'h0000_0002);
        rdc(ADDR_CMD_POS, 32'h0000_0005, "zero set");
        wr(ADDR_DESIRED, 32'h0000_0009);
        wr(ADDR_CTRL, 32'h0000_0004);
        rdc(ADDR_CMD_POS, 32'h0000_0009, "home set");
        wr(ADDR_BACKLASH, 32'h0000_0008);
        go(32'h0000_0014);
        idle();
        `CHK("motor", 32'h0000_0014, motor_pos)
        wr(ADDR_BACKLASH, 32'hFFFF_FFFC);
        go(32'h0000_000C);
        idle();
        `CHK("motor", 32'h0000_0008, motor_pos)
        // Rotary coordinates: the offset wraps into start..end.
        wr(ADDR_COORD_TYPE, 32'h1);
        wr(ADDR_END_POINT, 32'h0000_0063);
        wr(ADDR_START_POINT, 32'h0);
        wr(ADDR_ORIGIN, 32'h0);
        abs_pos <= 32'h0000_003C;
        restart();
        host.xfer(1'b0, ADDR_CMD_POS, 32'h0, o);
        `CHK("rot cmd", 32'h0000_003C, o)
        wr(ADDR_ORIGIN, host.new_origin(32'h0, 32'h0, o, 32'h0, 32'h0000_0063, 1'b1));
        restart();
        rdc(ADDR_ORIGIN_ACT, 32'h0000_0028, "rot origin");
        rdc(ADDR_CMD_POS, 32'h0, "rot cmd");
        `CHK("pitch ok", 1'b1, host.pitch_ok(8'h0A, 32'h0000_3F93))
        `CHK("pitch high", 1'b0, host.pitch_ok(8'h0D, 32'h0000_07F3))
        conclude();
    end
endmodule : home_offset_backlash_tb
`default_nettype wire
